// *** design/arr_pkg.sv ***
package arr_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_CHG_CUR_LO   = 8'h47;
    localparam logic [7:0] OFS_AUX_IN_HI    = 8'h48;
    localparam logic [7:0] OFS_AUX_IN_LO    = 8'h49;
    localparam logic [7:0] OFS_SUP_VOLT_HI  = 8'h4a;
    localparam logic [7:0] OFS_SUP_VOLT_LO  = 8'h4b;
    localparam logic [7:0] OFS_SYS_RAIL_HI  = 8'h4c;
    localparam logic [7:0] OFS_SYS_RAIL_LO  = 8'h4d;
    localparam logic [7:0] OFS_IN_CUR_HI    = 8'h4e;
    localparam logic [7:0] OFS_IN_CUR_LO    = 8'h4f;
    localparam logic [7:0] OFS_ALARM1_HI    = 8'h52;
    localparam logic [7:0] OFS_ALARM1_LO    = 8'h53;

    // Result bytes live in one array, indexed from the first result offset
    localparam int         RES_COUNT        = 9;
    localparam logic [3:0] IDX_CHG_CUR_LO   = 4'h0;
    localparam logic [3:0] IDX_AUX_IN_HI    = 4'h1;
    localparam logic [3:0] IDX_SUP_VOLT_HI  = 4'h3;
    localparam logic [3:0] IDX_SYS_RAIL_HI  = 4'h5;
    localparam logic [3:0] IDX_IN_CUR_HI    = 4'h7;

    // ************************************************************
    // Reset values and field layout of the alarm registers
    // ************************************************************
    localparam logic [7:0] RST_ALARM1_HI    = 8'h23;
    localparam logic [7:0] RST_ALARM1_LO    = 8'h20;
    localparam int         LO_THR_MSB       = 7;
    localparam int         LO_THR_LSB       = 4;
    localparam int         LO_DIR_BIT       = 3;
    localparam int         LO_RSV_MSB       = 2;
    localparam logic [7:0] RDATA_NONE       = 8'h00;

    // ************************************************************
    // Channel select codes
    // ************************************************************
    localparam logic [2:0] CH_DISABLED      = 3'h0;
    localparam logic [2:0] CH_AUX_INPUT     = 3'h1;
    localparam logic [2:0] CH_THERMISTOR    = 3'h2;
    localparam logic [2:0] CH_BATTERY       = 3'h3;
    localparam logic [2:0] CH_CHARGE_CUR    = 3'h4;
    localparam logic [2:0] CH_SUPPLY_VOLT   = 3'h5;
    localparam logic [2:0] CH_SYSTEM_RAIL   = 3'h6;
    localparam logic [2:0] CH_INPUT_CUR     = 3'h7;

    typedef struct packed {
        logic        valid;
        logic [2:0]  chan;
        logic [15:0] data;
    } arr_sample_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } arr_req_t;

endpackage : arr_pkg

// *** design/arr_regs.sv ***
`timescale 1ns/1ps

// How it works
// - Charge-current low result byte reads back at 0x47, read only.
// - Aux input result high byte at 0x48, low byte at 0x49, read only.
// - Supply voltage result high byte at 0x4a, low byte at 0x4b, read only.
// - System rail result high byte at 0x4c, low byte at 0x4d, read only.
// - Input current result high byte at 0x4e, low byte at 0x4f, read only.
// - Result bytes have no reset value; host writes never alter them.
// - Alarm one threshold bits 15:8 at 0x52, read-write, reset 0x23.
// - Register 0x53 resets to 0x20; upper nibble holds threshold bits 7:4.
// - Bit 3 of 0x53 picks alarm on falling below (0) or rising above (1).
// - Three-bit select picks monitored channel; code zero disables alarm one.
module arr_regs
    import arr_pkg::*;
#(
    parameter int RESULT_W = 16,
    parameter int THR_W    = 12
) (
    input  wire logic        clk_i,                     // 10 MHz clock
    input  wire logic        sys_rst_i,                 // Sync reset, active high
    input  wire arr_req_t    req_i,                     // Register request from bus engine
    input  wire arr_sample_t sample_i,                  // New conversion result
    input  wire logic [2:0]  alarm_one_channel_select_i,// Channel watched by alarm one
    output logic      [7:0]  rdata_o,                   // Read data, one cycle after rd
    output logic             rvalid_o,                  // Read data valid pulse
    output logic             alarm_one_event_o          // Alarm one crossing pulse
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (RESULT_W != 16 || THR_W != 12) begin : g_bad_param
        $error("arr_regs supports only 16-bit results and 12-bit thresholds");
    end

    // ************************************************************
    // Result storage
    // ************************************************************
    logic [7:0]  res_ff [RES_COUNT];
    logic [3:0]  hi_idx;

    always_comb begin
        case (sample_i.chan)
            CH_AUX_INPUT:   hi_idx = IDX_AUX_IN_HI;
            CH_SUPPLY_VOLT: hi_idx = IDX_SUP_VOLT_HI;
            CH_SYSTEM_RAIL: hi_idx = IDX_SYS_RAIL_HI;
            CH_INPUT_CUR:   hi_idx = IDX_IN_CUR_HI;
            default:        hi_idx = IDX_CHG_CUR_LO;
        endcase
    end

    // Only the converter loads results; bus writes never reach this array
    always_ff @(posedge clk_i) begin
        if (sample_i.valid) begin
            if (sample_i.chan == CH_CHARGE_CUR) begin
                res_ff[IDX_CHG_CUR_LO] <= sample_i.data[7:0];
            end else if (hi_idx != IDX_CHG_CUR_LO) begin
                res_ff[hi_idx]        <= sample_i.data[15:8];
                res_ff[hi_idx + 4'h1] <= sample_i.data[7:0];
            end
        end
    end

    // ************************************************************
    // Alarm one configuration
    // ************************************************************
    logic [7:0] thr_hi_ff;
    logic [7:0] thr_lo_ff;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            thr_hi_ff <= RST_ALARM1_HI;
        end else if (req_i.wr && req_i.addr == OFS_ALARM1_HI) begin
            thr_hi_ff <= req_i.wdata;
        end
    end

    // Whole byte stored, including the reserved bits
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            thr_lo_ff <= RST_ALARM1_LO;
        end else if (req_i.wr && req_i.addr == OFS_ALARM1_LO) begin
            thr_lo_ff <= req_i.wdata;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    logic [7:0] nxt_rdata;
    logic [7:0] rel_addr;

    assign rel_addr = req_i.addr - OFS_CHG_CUR_LO;

    always_comb begin
        nxt_rdata = RDATA_NONE;
        if (req_i.addr >= OFS_CHG_CUR_LO && req_i.addr <= OFS_IN_CUR_LO) begin
            nxt_rdata = res_ff[rel_addr[3:0]];
        end else if (req_i.addr == OFS_ALARM1_HI) begin
            nxt_rdata = thr_hi_ff;
        end else if (req_i.addr == OFS_ALARM1_LO) begin
            nxt_rdata = thr_lo_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o  <= RDATA_NONE;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                rdata_o <= nxt_rdata;
            end
        end
    end

    // ************************************************************
    // Alarm one comparator
    // ************************************************************
    logic [THR_W-1:0] thr_val;
    logic [THR_W-1:0] meas_top;
    logic             watch_hit;
    logic             cond_now;
    logic             cond_ff;

    // Low four result bits are ignored, as if the threshold ended in zeros below and in ones above
    assign thr_val   = {thr_hi_ff, thr_lo_ff[LO_THR_MSB:LO_THR_LSB]};
    assign meas_top  = sample_i.data[RESULT_W-1:RESULT_W-THR_W];
    assign watch_hit = sample_i.valid && alarm_one_channel_select_i != CH_DISABLED
                       && sample_i.chan == alarm_one_channel_select_i;
    assign cond_now  = thr_lo_ff[LO_DIR_BIT] ? (meas_top > thr_val)
                                             : (meas_top < thr_val);

    // Event only on entering the condition, so a steady level raises it once
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cond_ff           <= 1'b0;
            alarm_one_event_o <= 1'b0;
        end else begin
            alarm_one_event_o <= watch_hit && cond_now && !cond_ff;
            if (watch_hit) begin
                cond_ff <= cond_now;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_read(logic [7:0] a);
        req_i.rd && req_i.addr == a && !sample_i.valid;
    endsequence

    chk_thr_hi_reset: assert property (@(posedge clk_i)
        sys_rst_i |=> thr_hi_ff == RST_ALARM1_HI && rdata_o == RDATA_NONE)
        else $error("threshold high byte not reset to 0x23");

    chk_thr_lo_reset: assert property (@(posedge clk_i)
        sys_rst_i |=> thr_lo_ff == RST_ALARM1_LO)
        else $error("threshold low register not reset to 0x20");

    chk_charge_current_channel_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_read(8'h47) |=> rvalid_o && rdata_o == $past(res_ff[0]))
        else $error("charge current low byte read wrong");

    // A host read lands two cycles after the sample at the earliest
    chk_aux_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sample_i.valid && sample_i.chan == CH_AUX_INPUT ##1 !sample_i.valid
        ##1 s_read(OFS_AUX_IN_HI)
        |=> rdata_o == $past(sample_i.data[15:8], 3))
        else $error("aux input high byte read wrong");

    chk_vin_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sample_i.valid && sample_i.chan == CH_SUPPLY_VOLT ##1 !sample_i.valid
        ##1 s_read(OFS_SUP_VOLT_HI)
        |=> rdata_o == $past(sample_i.data[15:8], 3))
        else $error("supply voltage high byte read wrong");

    chk_rail_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sample_i.valid && sample_i.chan == CH_SYSTEM_RAIL ##1 !sample_i.valid
        ##1 s_read(OFS_SYS_RAIL_HI)
        |=> rdata_o == $past(sample_i.data[15:8], 3))
        else $error("system rail high byte read wrong");

    chk_iin_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sample_i.valid && sample_i.chan == CH_INPUT_CUR ##1 !sample_i.valid
        ##1 s_read(OFS_IN_CUR_HI)
        |=> rdata_o == $past(sample_i.data[15:8], 3))
        else $error("input current high byte read wrong");

    chk_ro_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        req_i.wr && req_i.addr == 8'h4a && !sample_i.valid |=> $stable(res_ff[3]))
        else $error("write altered a result byte");

    chk_dir_event: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        alarm_one_event_o |-> $past(thr_lo_ff[3]) ? $past(meas_top > thr_val)
                                                  : $past(meas_top < thr_val))
        else $error("alarm raised against selected direction");

    chk_chan_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        alarm_one_channel_select_i == 3'h0 |=> !alarm_one_event_o)
        else $error("alarm raised while disabled");

    chk_cmp_trunc: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        watch_hit && !thr_lo_ff[3] && sample_i.data[15:4] >= thr_val |=> !alarm_one_event_o)
        else $error("alarm below raised for equal or higher top bits");

    chk_rsv_store: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        req_i.wr && req_i.addr == 8'h53 |=> thr_lo_ff[2:0] == $past(req_i.wdata[2:0]))
        else $error("reserved bits not stored");

    chk_thr_hi_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        req_i.wr && req_i.addr == OFS_ALARM1_HI |=> thr_hi_ff == $past(req_i.wdata))
        else $error("threshold high byte write not stored");

    chk_rvalid_rise: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        req_i.rd |=> rvalid_o)
        else $error("read answer strobe missing");

    chk_rvalid_fall: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !req_i.rd |=> !rvalid_o)
        else $error("read answer strobe without a read");

endmodule : arr_regs

// *** verif/arr_host.sv ***
`timescale 1ns/1ps
// ****
// Host side of the register port
// ****
module arr_host
    import arr_pkg::*;
(
    input  wire logic       clk_i,    // System clock
    input  wire logic       rvalid_i, // Read answer strobe
    input  wire logic [7:0] rdata_i,  // Read answer data
    output arr_req_t        req_o     // Request to the bank
);
    initial begin
        req_o = '0;
    end

    // Request held for exactly one taking edge, then dropped
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        req_o <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        req_o <= '0;
        #1;
        ok = rvalid_i;
        d  = rdata_i;
    endtask : rd
endmodule : arr_host

// *** verif/adc_result_and_alarm_regs_tb.sv ***
`timescale 1ns/1ps
module adc_result_and_alarm_regs_tb;
    import arr_pkg::*;
    logic        clk_i;
    logic        sys_rst_i;
    arr_req_t    req;
    arr_sample_t sample;
    logic [2:0]  sel;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        alarm;
    int          n_fail = 0;
    int          compares = 0;
    int          cycles = 0;

    arr_regs u_arr_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .sample_i(sample),
        .alarm_one_channel_select_i(sel), .rdata_o(rdata), .rvalid_o(rvalid),
        .alarm_one_event_o(alarm));
    arr_host u_arr_host (.clk_i(clk_i), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // A hang costs at most a few hundred microseconds of run time
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ****
    // Shared helpers
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_arr_host.rd(a, d, ok);
        check({7'h00, ok}, 8'h01, "read answer");
        check(d, exp, $sformatf("read of %h", a));
    endtask : rd_chk

    task automatic samp(input logic [2:0] ch, input logic [15:0] d, input logic exp);
        @(posedge clk_i);
        sample <= '{valid: 1'b1, chan: ch, data: d};
        @(posedge clk_i);
        sample <= '0;
        #1;
        check({7'h00, alarm}, {7'h00, exp}, "alarm pulse");
    endtask : samp

    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        rd_chk(OFS_ALARM1_HI, RST_ALARM1_HI);
        rd_chk(OFS_ALARM1_LO, RST_ALARM1_LO);
        rd_chk(8'h50, RDATA_NONE);
        $display("test reset done");
    endtask : t_reset

    task automatic t_results();
        logic [2:0]  chs [4] = '{CH_AUX_INPUT, CH_SUPPLY_VOLT, CH_SYSTEM_RAIL, CH_INPUT_CUR};
        logic [7:0]  ofs [4] = '{OFS_AUX_IN_HI, OFS_SUP_VOLT_HI, OFS_SYS_RAIL_HI, OFS_IN_CUR_HI};
        logic [15:0] d;
        for (int i = 0; i < 4; i++) begin
            d = 16'ha1b2 + 16'(16'h1111 * i);
            samp(chs[i], d, 1'b0);
            rd_chk(ofs[i], d[15:8]);
            rd_chk(ofs[i] + 8'h01, d[7:0]);
            u_arr_host.wr(ofs[i], ~d[15:8]);
            u_arr_host.wr(ofs[i] + 8'h01, ~d[7:0]);
            rd_chk(ofs[i], d[15:8]);
            rd_chk(ofs[i] + 8'h01, d[7:0]);
        end
        samp(CH_BATTERY, 16'h0000, 1'b0);
        rd_chk(OFS_AUX_IN_HI, 8'ha1);
        samp(CH_CHARGE_CUR, 16'hbeef, 1'b0);
        rd_chk(OFS_CHG_CUR_LO, 8'hef);
        u_arr_host.wr(OFS_CHG_CUR_LO, 8'h10);
        rd_chk(OFS_CHG_CUR_LO, 8'hef);
        $display("test results done");
    endtask : t_results

    task automatic t_alarm();
        @(posedge clk_i);
        sel <= CH_SUPPLY_VOLT;
        u_arr_host.wr(OFS_ALARM1_HI, 8'h40);
        u_arr_host.wr(OFS_ALARM1_LO, 8'h07);
        rd_chk(OFS_ALARM1_HI, 8'h40);
        rd_chk(OFS_ALARM1_LO, 8'h07);
        samp(CH_SUPPLY_VOLT, 16'h4100, 1'b0);
        samp(CH_SUPPLY_VOLT, 16'h4000, 1'b0);
        samp(CH_SUPPLY_VOLT, 16'h3ff0, 1'b1);
        samp(CH_SUPPLY_VOLT, 16'h3000, 1'b0);
        samp(CH_SYSTEM_RAIL, 16'h5000, 1'b0);
        samp(CH_SUPPLY_VOLT, 16'h3000, 1'b0);
        u_arr_host.wr(OFS_ALARM1_LO, 8'h0a);
        rd_chk(OFS_ALARM1_LO, 8'h0a);
        samp(CH_SUPPLY_VOLT, 16'h4000, 1'b0);
        samp(CH_SUPPLY_VOLT, 16'h400f, 1'b0);
        samp(CH_SUPPLY_VOLT, 16'h4010, 1'b1);
        for (int c = 1; c < 8; c++) begin
            @(posedge clk_i);
            sel <= c[2:0];
            samp(c[2:0], 16'h3000, 1'b0);
            samp(c[2:0], 16'h5000, 1'b1);
        end
        @(posedge clk_i);
        sel <= CH_DISABLED;
        samp(CH_SUPPLY_VOLT, 16'h3000, 1'b0);
        samp(CH_SUPPLY_VOLT, 16'h5000, 1'b0);
        $display("test alarm done");
    endtask : t_alarm

    task automatic tally_and_finish();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        sys_rst_i = 1'b1;
        sample    = '0;
        sel       = CH_DISABLED;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_results();
        t_alarm();
        tally_and_finish();
    end
endmodule : adc_result_and_alarm_regs_tb
